// [hdl/spi_front.v]
// Serial memory SPI slave: command decode, address framing, write latch, storage
`timescale 1ns/1ps
`include "spi_front_map.vh"

// Behaviour
// - 2048 bytes, low 11 address bits used
// - each byte queued in a two-entry buffer if the latch is set and it is not full (else dropped), written when the write port takes it
// - SPI slave, modes 0 and 3, 15 MHz
// - sample input on rising clock after select
// - change output on falling clock edges
// - first byte opcode, then address and data
// - deselected: ignore input, output tristated
// - all bytes shifted MSB first
// - bad opcode ignored until next select
// - clock level at select picks mode
// - mode 3 skips initial clock toggle
// - decode set, clear, status read opcodes
// - decode status write, read, write opcodes
// - latch cleared at power up
// - set opcode sets latch; status write can't
// - latch clears when write-type frame ends
// - clear opcode clears latch, reads zero
// - status read returns status byte
// - latch flag bit 1, others zero
module spi_front (
    input  wire sys_clk,
    input  wire resetn,
    input  wire cs_n,
    input  wire sck,
    input  wire si,
    output reg  so_out_ff,
    output reg  so_oe_ff,
    output reg  write_latch_flag_ff,
    output reg  wr_valid_ff,
    input  wire wr_ready,
    output reg  [7:0] wr_data_ff,
    output reg  [10:0] wr_addr_ff
);
    localparam ST_IDLE = 6'b000001;
    localparam ST_OP   = 6'b000010;
    localparam ST_ADDR = 6'b000100;
    localparam ST_DATA = 6'b001000;
    localparam ST_STAT = 6'b010000;
    localparam ST_DEAD = 6'b100000;
    localparam [1:0] MODE_RD = 2'd1;
    localparam [1:0] MODE_WR = 2'd2;
    localparam [1:0] MODE_SW = 2'd3;

    reg        rst_a_ff;
    reg        rst_b_ff;
    reg  [1:0] cs_sync_ff;
    reg  [1:0] sck_sync_ff;
    reg  [1:0] si_sync_ff;
    reg        cs_d_ff;
    reg        sck_d_ff;
    reg  [5:0] state_ff;
    reg  [2:0] bit_cnt_ff;
    reg  [7:0] shift_ff;
    reg  [7:0] tx_ff;
    reg        addr_hi_ff;
    reg  [1:0] mode_ff;
    reg        skip_rise_ff;
    reg        clr_on_end_ff;
    reg  [10:0] addr_ff;
    reg  [7:0] mem [0:`MEM_DEPTH-1];
    reg  [7:0] buf_data [0:1];
    reg  [10:0] buf_addr [0:1];
    reg        wp_ff;
    reg        rp_ff;
    reg  [1:0] cnt_ff;

    wire rst_n   = rst_b_ff;
    wire cs_l    = cs_sync_ff[1];
    wire sck_l   = sck_sync_ff[1];
    wire si_l    = si_sync_ff[1];
    wire sel_beg = cs_d_ff & ~cs_l;
    wire sel_end = ~cs_d_ff & cs_l;
    wire rise    = ~cs_l & ~sck_d_ff & sck_l;
    wire fall    = ~cs_l & sck_d_ff & ~sck_l;
    wire [7:0] rx_byte = {shift_ff[6:0], si_l};
    wire [7:0] status_byte = {6'h00, write_latch_flag_ff, 1'b0};
    wire byte_done = rise & ~skip_rise_ff & (bit_cnt_ff == 3'd7);
    wire buf_full  = (cnt_ff == 2'd2);
    wire push = byte_done & (state_ff == ST_DATA) & (mode_ff == MODE_WR) & ~buf_full;
    wire pop  = wr_valid_ff & wr_ready;

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_a_ff <= 1'b0;
            rst_b_ff <= 1'b0;
        end else begin
            rst_a_ff <= 1'b1;
            rst_b_ff <= rst_a_ff;
        end
    end

    // Pins are asynchronous to sys_clk; sck at 15 MHz still gives over six samples a phase
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_sync_ff  <= 2'b11;
            sck_sync_ff <= 2'b00;
            si_sync_ff  <= 2'b00;
            cs_d_ff     <= 1'b1;
            sck_d_ff    <= 1'b0;
        end else begin
            cs_sync_ff  <= {cs_sync_ff[0], cs_n};
            sck_sync_ff <= {sck_sync_ff[0], sck};
            si_sync_ff  <= {si_sync_ff[0], si};
            cs_d_ff     <= cs_l;
            sck_d_ff    <= sck_l;
        end
    end

    // Command decoder
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff            <= ST_IDLE;
            bit_cnt_ff          <= 3'd0;
            shift_ff            <= 8'h00;
            addr_hi_ff          <= 1'b0;
            mode_ff             <= 2'd0;
            skip_rise_ff        <= 1'b0;
            clr_on_end_ff       <= 1'b0;
            addr_ff             <= 11'h000;
            write_latch_flag_ff <= 1'b0;
        end else if (sel_end || cs_l) begin
            state_ff   <= ST_IDLE;
            bit_cnt_ff <= 3'd0;
            if (sel_end && clr_on_end_ff)
                write_latch_flag_ff <= 1'b0;
            clr_on_end_ff <= 1'b0;
        end else if (sel_beg) begin
            state_ff      <= ST_OP;
            bit_cnt_ff    <= 3'd0;
            skip_rise_ff  <= sck_l;
            addr_hi_ff    <= 1'b0;
            clr_on_end_ff <= 1'b0;
        end else if (fall && skip_rise_ff) begin
            // Mode 3 idles high; the first fall is the initial toggle, the next rise samples
            skip_rise_ff <= 1'b0;
        end else if (rise) begin
            if (skip_rise_ff) begin
                // A mode 3 select sees the clock already high; no bit is sampled there
                skip_rise_ff <= 1'b0;
            end else if (state_ff != ST_DEAD && state_ff != ST_IDLE) begin
                shift_ff   <= rx_byte;
                bit_cnt_ff <= bit_cnt_ff + 3'd1;
                if (bit_cnt_ff == 3'd7) begin
                    case (state_ff)
                        ST_OP: begin
                            case (rx_byte)
                                `OP_SET_WRITE_LATCH: begin
                                    write_latch_flag_ff <= 1'b1;
                                    state_ff <= ST_DEAD;
                                end
                                `OP_CLEAR_WRITE_LATCH: begin
                                    clr_on_end_ff <= 1'b1;
                                    state_ff <= ST_DEAD;
                                end
                                `OP_STATUS_READ: state_ff <= ST_STAT;
                                `OP_STATUS_WRITE: begin
                                    // Only the latch lives here and a status write clears it when the frame ends
                                    clr_on_end_ff <= 1'b1;
                                    state_ff <= ST_DEAD;
                                end
                                `OP_MEM_READ: begin
                                    mode_ff  <= MODE_RD;
                                    state_ff <= ST_ADDR;
                                end
                                `OP_MEM_WRITE: begin
                                    mode_ff  <= MODE_WR;
                                    clr_on_end_ff <= 1'b1;
                                    state_ff <= ST_ADDR;
                                end
                                default: state_ff <= ST_DEAD;
                            endcase
                        end
                        ST_ADDR: begin
                            if (!addr_hi_ff) begin
                                addr_ff[10:8] <= rx_byte[2:0];
                                addr_hi_ff    <= 1'b1;
                            end else begin
                                addr_ff[7:0] <= rx_byte;
                                state_ff     <= ST_DATA;
                            end
                        end
                        ST_DATA: begin
                            if (mode_ff == MODE_RD || !write_latch_flag_ff || !buf_full)
                                addr_ff <= addr_ff + 11'd1;
                        end
                        default: state_ff <= state_ff;
                    endcase
                end
            end
        end
    end

    // Output drives on falling edges; the byte to send loads when a read byte boundary is met
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_ff     <= 8'h00;
            so_out_ff <= 1'b0;
            so_oe_ff  <= 1'b0;
        end else if (cs_l || state_ff == ST_DEAD || state_ff == ST_IDLE) begin
            so_oe_ff  <= 1'b0;
            so_out_ff <= 1'b0;
        end else if (fall && bit_cnt_ff == 3'd0 &&
                     (state_ff == ST_STAT || (state_ff == ST_DATA && mode_ff == MODE_RD))) begin
            so_oe_ff  <= 1'b1;
            so_out_ff <= (state_ff == ST_STAT) ? status_byte[7] : mem[addr_ff][7];
            tx_ff     <= (state_ff == ST_STAT) ? {status_byte[6:0], 1'b0}
                                               : {mem[addr_ff][6:0], 1'b0};
        end else if (fall && so_oe_ff) begin
            so_out_ff <= tx_ff[7];
            tx_ff     <= {tx_ff[6:0], 1'b0};
        end
    end

    // Two-entry buffer to the write port; the array takes each byte as it leaves
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_ff       <= 1'b0;
            rp_ff       <= 1'b0;
            cnt_ff      <= 2'd0;
            wr_valid_ff <= 1'b0;
            wr_data_ff  <= 8'h00;
            wr_addr_ff  <= 11'h000;
        end else begin
            if (push && write_latch_flag_ff) begin
                buf_data[wp_ff] <= rx_byte;
                buf_addr[wp_ff] <= addr_ff;
                wp_ff <= ~wp_ff;
            end
            if (pop) begin
                mem[wr_addr_ff] <= wr_data_ff;
                rp_ff <= ~rp_ff;
            end
            cnt_ff <= cnt_ff + {1'b0, push & write_latch_flag_ff} - {1'b0, pop};
            if (!wr_valid_ff || pop) begin
                if (cnt_ff - {1'b0, pop} != 2'd0) begin
                    wr_valid_ff <= 1'b1;
                    wr_data_ff  <= buf_data[rp_ff ^ pop];
                    wr_addr_ff  <= buf_addr[rp_ff ^ pop];
                end else begin
                    wr_valid_ff <= 1'b0;
                end
            end
        end
    end
endmodule

// [hdl/spi_front_map.vh]
// Constants for the serial memory command front end
`ifndef SPI_FRONT_MAP_VH
`define SPI_FRONT_MAP_VH
`define OP_SET_WRITE_LATCH   8'h06
`define OP_CLEAR_WRITE_LATCH 8'h04
`define OP_STATUS_READ       8'h05
`define OP_STATUS_WRITE      8'h01
`define OP_MEM_READ          8'h03
`define OP_MEM_WRITE         8'h02
`define ADDR_BITS            11
`define MEM_DEPTH            2048
`define STAT_LATCH_BIT       1
`define SCK_MAX_KHZ          15000
`define SYS_CLK_KHZ          200000
`endif

// [tb/spi_front_properties.sv]
// Port-level assertions for the serial memory front end
`timescale 1ns/1ps
module spi_front_properties (
    input wire        sys_clk,
    input wire        resetn,
    input wire        cs_n,
    input wire        sck,
    input wire        si,
    input wire        so_out_ff,
    input wire        so_oe_ff,
    input wire        write_latch_flag_ff,
    input wire        wr_valid_ff,
    input wire        wr_ready,
    input wire [7:0]  wr_data_ff,
    input wire [10:0] wr_addr_ff
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    AST_OE_DESEL: assert property (cs_n [*5] |-> !so_oe_ff)
        else $error("so driven while deselected");
    AST_OE_RISE: assert property ($rose(so_oe_ff) |-> !cs_n)
        else $error("so enabled outside a frame");
    AST_SO_EDGE: assert property (so_oe_ff && $changed(so_out_ff) |-> !sck)
        else $error("so moved while serial clock high");
    AST_WR_DESEL: assert property (cs_n [*6] |-> !$rose(wr_valid_ff))
        else $error("write issued while deselected");
    AST_HOLD: assert property (wr_valid_ff && !wr_ready |=>
        wr_valid_ff && $stable(wr_data_ff) && $stable(wr_addr_ff))
        else $error("stalled write head changed");
    AST_WR_LATCH: assert property ($rose(wr_valid_ff) |-> write_latch_flag_ff)
        else $error("write without latch");
    AST_LATCH_SET: assert property ($rose(write_latch_flag_ff) |-> !cs_n)
        else $error("latch set outside a frame");
    AST_LATCH_CLR: assert property ($fell(write_latch_flag_ff) |->
        cs_n && $past(cs_n, 2))
        else $error("latch cleared before deselect");
endmodule
bind spi_front spi_front_properties props (.sys_clk(sys_clk), .resetn(resetn), .cs_n(cs_n),
    .sck(sck), .si(si), .so_out_ff(so_out_ff), .so_oe_ff(so_oe_ff),
    .write_latch_flag_ff(write_latch_flag_ff), .wr_valid_ff(wr_valid_ff),
    .wr_ready(wr_ready), .wr_data_ff(wr_data_ff), .wr_addr_ff(wr_addr_ff));

// [tb/spi_master_model.sv]
// Behavioural SPI bus master for the front end
`timescale 1ns/1ps
module spi_master_model (
    output logic cs_n,
    output logic sck,
    output logic si,
    input  wire  so_out_ff,
    input  wire  so_oe_ff
);
    logic so_last;
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        so_last = 1'b0;
    end
    // Opcode then n tail bytes, top byte of tail first; rx keeps the last byte read back
    task automatic frame(input logic [7:0] op, input logic [39:0] tl, input int n,
                         input logic mode3, output logic [7:0] rx, output logic oe_seen);
        logic [47:0] sh;
        sh = {op, tl};
        rx = 8'h00;
        oe_seen = 1'b0;
        #1.3 sck = mode3;
        #62.5 cs_n = 1'b0;
        for (int b = 0; b < 8 * (n + 1); b++) begin
            #62.5 sck = 1'b0;
            si = sh[47];
            sh = sh << 1;
            #62.5 sck = 1'b1;
            // No pull on the line: a released output reads as the inverse of the last bit
            so_last = so_oe_ff ? so_out_ff : ~so_last;
            rx = {rx[6:0], so_last};
            oe_seen = oe_seen | so_oe_ff;
        end
        #62.5 sck = mode3;
        #62.5 cs_n = 1'b1;
        si = ~si;
        #250;
    endtask
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the serial memory front end
`timescale 1ns/1ps
`include "spi_front_map.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %0t: got %0h want %0h", $time, g, e); end end
module tb_top;
    typedef struct packed {logic [7:0] op; logic [39:0] tl; logic [2:0] n; logic [7:0] rx;
        logic write_latch_flag;} row_t;
    localparam int power_up_delay = 20;
    logic sys_clk, resetn, wr_ready, so_out_ff, so_oe_ff, write_latch_flag_ff, wr_valid_ff;
    wire cs_n, sck, si;
    logic [7:0] wr_data_ff, rx;
    logic [10:0] wr_addr_ff;
    logic [18:0] wlog [$];
    logic oe, exp_oe;
    int error_cnt, samples_checked, i, k;
    row_t rows [0:10] = '{'{`OP_SET_WRITE_LATCH, 40'h0, 3'd0, 8'h00, 1'b1},
        '{`OP_STATUS_READ, 40'h0, 3'd1, 8'h02, 1'b1},
        '{`OP_STATUS_WRITE, 40'hff00000000, 3'd1, 8'h00, 1'b0},
        '{`OP_STATUS_READ, 40'h0, 3'd1, 8'h00, 1'b0},
        '{`OP_SET_WRITE_LATCH, 40'h0, 3'd0, 8'h00, 1'b1},
        '{`OP_CLEAR_WRITE_LATCH, 40'h0, 3'd0, 8'h00, 1'b0},
        '{`OP_STATUS_READ, 40'h0, 3'd1, 8'h00, 1'b0},
        '{`OP_SET_WRITE_LATCH, 40'h0, 3'd0, 8'h00, 1'b1},
        '{`OP_MEM_WRITE, 40'hf7fea55a00, 3'd4, 8'h00, 1'b0},
        '{`OP_MEM_READ, 40'h07fe000000, 3'd3, 8'ha5, 1'b0},
        '{8'h07, 40'h0, 3'd1, 8'h00, 1'b0}};
    spi_front uut (.sys_clk(sys_clk), .resetn(resetn), .cs_n(cs_n), .sck(sck), .si(si),
        .so_out_ff(so_out_ff), .so_oe_ff(so_oe_ff), .write_latch_flag_ff(write_latch_flag_ff),
        .wr_valid_ff(wr_valid_ff), .wr_ready(wr_ready), .wr_data_ff(wr_data_ff),
        .wr_addr_ff(wr_addr_ff));
    spi_master_model master (.cs_n(cs_n), .sck(sck), .si(si), .so_out_ff(so_out_ff),
        .so_oe_ff(so_oe_ff));
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (wr_valid_ff === 1'b1 && wr_ready === 1'b1) begin
            wlog.push_back({wr_addr_ff, wr_data_ff});
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        resetn = 1'b0;
        wr_ready = 1'b1;
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (power_up_delay) @(posedge sys_clk);
        // Odd rows run in mode 3 so set and status read are each seen in both clock modes
        for (i = 0; i < 11; i++) begin
            master.frame(rows[i].op, rows[i].tl, rows[i].n, i[0], rx, oe);
            exp_oe = rows[i].op inside {`OP_STATUS_READ, `OP_MEM_READ};
            `CHK(write_latch_flag_ff, rows[i].write_latch_flag)
            `CHK(oe, exp_oe)
            if (exp_oe) `CHK(rx, rows[i].rx)
            $display("row %0d done", i);
        end
        `CHK(wlog.size(), 2)
        `CHK(wlog[0], {11'h7fe, 8'ha5})
        `CHK(wlog[1], {11'h7ff, 8'h5a})
        wlog.delete();
        master.frame(`OP_MEM_WRITE, 40'h000100ab00, 3, 1'b0, rx, oe);
        `CHK(wlog.size(), 0)
        $display("locked write done");
        @(posedge sys_clk) wr_ready <= 1'b0;
        master.frame(`OP_SET_WRITE_LATCH, 40'h0, 0, 1'b1, rx, oe);
        master.frame(`OP_MEM_WRITE, 40'h07ff112233, 5, 1'b1, rx, oe);
        `CHK({wr_valid_ff, wr_addr_ff, wr_data_ff}, {1'b1, 11'h7ff, 8'h11})
        @(posedge sys_clk) wr_ready <= 1'b1;
        for (k = 0; k < 100 && wlog.size() < 2; k++) @(posedge sys_clk);
        `CHK(k < 100, 1'b1)
        repeat (20) @(posedge sys_clk);
        #1;
        `CHK(wlog.size(), 2)
        `CHK(wlog[1], {11'h000, 8'h22})
        $display("stall done");
        master.frame(`OP_SET_WRITE_LATCH, 40'h0, 0, 1'b0, rx, oe);
        @(posedge sys_clk) resetn <= 1'b0;
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        `CHK(write_latch_flag_ff, 1'b0)
        $display("reset done");
        end_of_test();
    end
endmodule
